// ==== hdl/ssm_pkg.sv ====
// constants, register map and encodings for the security and stream mapping front end
package ssm_pkg;
   localparam int NUM_ENTRIES = 8;
   localparam int ENTRY_IDX_W = 3;
   localparam int SID_W = 16;
   localparam int TID_W = 14;
   localparam int DT_IDX_W = 5;
   localparam int CB_W = 4;
   // register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h0_000;
   localparam logic [11:0] OFF_ID0 = 12'h0_004;
   localparam logic [11:0] OFF_ID1 = 12'h0_008;
   localparam logic [11:0] OFF_DTAB = 12'h0_00C;
   localparam logic [11:0] OFF_CTRL_ALIAS = 12'h0_010;
   localparam logic [11:0] OFF_STATUS = 12'h0_014;
   localparam logic [11:0] OFF_MATCH = 12'h0_080;
   localparam logic [11:0] OFF_S2C = 12'h0_0C0;
   localparam logic [11:0] OFF_BLOCK_MASK = 12'h0_FE0;
   // control fields
   localparam int CTRL_EXT_EN = 0;
   localparam int CTRL_NOMATCH = 1;
   localparam int CTRL_MULTI = 2;
   localparam int CTRL_INDEX = 3;
   localparam int CTRL_SIDEBAND = 4;
   localparam int CTRL_W = 5;
   localparam logic [4:0] CTRL_RESET = 5'h0_0;
   // identification fields
   localparam logic [3:0] ID_WIDTH_FIELD = 4'hF;
   localparam int ID0_EXT_CAP = 4;
   localparam int ID0_MATCH_SUP = 5;
   localparam int ID1_DT_PRESENT = 0;
   // match register fields
   localparam int MR_ID_LSB = 0;
   localparam int MR_MASK_LSB = 16;
   localparam int MR_VALID = 31;
   localparam logic [31:0] MR_RESET = 32'h0000_0000;
   // stream to context entry fields
   localparam int S2C_TYPE_LSB = 0;
   localparam int S2C_CB_LSB = 4;
   localparam int S2C_SEC_OWNED = 8;
   localparam int S2C_EXT_VALID = 9;
   localparam int S2C_FORCE_NS = 10;
   localparam logic [10:0] S2C_RESET = 11'h0_02;
   localparam logic [31:0] DTAB_RESET = 32'hFFFF_FFFF;
   typedef enum logic [1:0] {
      SSM_OUT_TRANSLATE = 2'b00,
      SSM_OUT_BYPASS = 2'b01,
      SSM_OUT_FAULT = 2'b10
   } ssm_outcome_e;
   typedef enum logic [1:0] {
      SSM_FLT_NONE = 2'b00,
      SSM_FLT_UNIDENT = 2'b01,
      SSM_FLT_CONFLICT = 2'b10,
      SSM_FLT_ENTRY = 2'b11
   } ssm_fault_e;
endpackage

// ==== hdl/ssm_top.sv ====
// security domain decision, stream identifier and stream mapping with apb registers
//
// Notes on behaviour
// [RL1] domain is decided first and steers all later mapping choices
// [RL2] non-secure domain source never leaves with secure marking
// [RL3] domain is kept apart from the incoming bus security attribute
// [RL4] requesters keep one domain per stream; the domain is taken per transaction, so one stream can take either domain
// [RL5] with domain table, indexed bit 0 means secure, 1 non-secure
// [RL6] secure software programs and reads back the domain table first
// [RL7] without the table, domain comes from a sideband input
// [RL8] banked control: secure and non-secure accesses reach separate copies
// [RL9] secure-owned entries are invisible to non-secure accesses
// [RL10] alias offset lets secure software reach the non-secure control copy
// [RL11] each transaction ends in bypass, fault or context bank processing
// [RL12] same stream identifier always maps to same entry and processing; here the domain's control copy also decides the entry
// [RL13] stream identifier built from transaction id, read flag and bus security
// [RL14] four-bit width field reports identifier bits
// [RL15] sixteen-bit identifiers flagged by capability bit and width field 15
// [RL16] extended enable uses 16-bit identifiers and extended match format
// [RL17] a zero-width identifier is allowed for a single dedicated source
// [RL18] matching compares all entries; only a unique hit selects its entry
// [RL19] up to 128 match groups, 1024 with extended matching; this design holds 8 entries in either format
// [RL20] baseline match registers are the last entries of the extended set
// [RL21] indexing mode: identifier m selects entry m directly
// [RL22] no hit: control field chooses bypass or unidentified stream fault
// [RL23] several hits: control field chooses bypass or conflict fault
`timescale 1ns/100ps
module ssm_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [2:0] pprot,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic txn_valid,
   input wire logic [13:0] txn_id,
   input wire logic txn_read,
   input wire logic txn_bus_ns,
   input wire logic txn_sideband_secure,
   input wire logic [4:0] domain_table_index,
   output logic out_valid,
   output logic out_ns,
   output logic out_secure_domain,
   output logic [1:0] out_outcome,
   output logic [1:0] out_fault,
   output logic [2:0] out_entry,
   output logic [3:0] out_context,
   output logic [15:0] stream_identifier
);
   logic [4:0] ctrl_s_reg;
   logic [4:0] ctrl_ns_reg;
   logic [31:0] domain_table_register;
   logic [31:0] match_register [ssm_pkg::NUM_ENTRIES];
   logic [10:0] stream_to_context_entry [ssm_pkg::NUM_ENTRIES];
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic out_valid_reg;
   logic out_ns_reg;
   logic out_sec_reg;
   logic [1:0] out_outcome_reg;
   logic [1:0] out_fault_reg;
   logic [2:0] out_entry_reg;
   logic [3:0] out_context_reg;
   logic [15:0] sid_reg;

   function automatic logic entry_hit(input logic [15:0] sid, input logic [31:0] mr,
                                      input logic ext_valid, input logic ext);
      logic [15:0] cmp_mask;
      logic [15:0] cmp_id;
      logic vld;
      cmp_mask = 16'h0000;
      cmp_id = 16'h0000;
      vld = 1'b0;
      if (ext)
      begin
         cmp_id = mr[ssm_pkg::MR_ID_LSB +: 16];
         cmp_mask = mr[ssm_pkg::MR_MASK_LSB +: 16];
         vld = ext_valid;
      end
      else
      begin
         cmp_id = {1'b0, mr[ssm_pkg::MR_ID_LSB +: 15]};
         cmp_mask = {1'b1, mr[ssm_pkg::MR_MASK_LSB +: 15]};
         vld = mr[ssm_pkg::MR_VALID];
      end
      entry_hit = vld && (((sid ^ cmp_id) & ~cmp_mask) == 16'h0000);
   endfunction

   // apb decode; pprot[1] low marks a secure configuration access
   wire apb_secure = ~pprot[1];
   wire apb_setup = psel & penable & ~pready_reg;
   wire apb_commit = psel & penable & pready_reg;
   wire apb_wr = apb_commit & pwrite;
   wire [11:0] blk_addr = paddr & ssm_pkg::OFF_BLOCK_MASK;
   wire [2:0] reg_idx = paddr[4:2];
   wire sel_match = blk_addr == ssm_pkg::OFF_MATCH;
   wire sel_s2c = blk_addr == ssm_pkg::OFF_S2C;
   wire idx_sec_owned = stream_to_context_entry[reg_idx][ssm_pkg::S2C_SEC_OWNED];
   wire entry_visible = apb_secure | ~idx_sec_owned; // RL9
   wire sel_ctrl = paddr == ssm_pkg::OFF_CTRL;
   wire sel_alias = paddr == ssm_pkg::OFF_CTRL_ALIAS;
   wire sel_dtab = paddr == ssm_pkg::OFF_DTAB;
   wire mapped = sel_ctrl | sel_alias | sel_dtab | sel_match | sel_s2c |
                 paddr == ssm_pkg::OFF_ID0 | paddr == ssm_pkg::OFF_ID1 |
                 paddr == ssm_pkg::OFF_STATUS;
   wire [4:0] ctrl_view = apb_secure ? ctrl_s_reg : ctrl_ns_reg; // RL8
   wire [31:0] id0_word = {26'h000_0000, 1'b1, 1'b1, ssm_pkg::ID_WIDTH_FIELD}; // RL14 RL15
   wire [31:0] id1_word = {31'h0000_0000, 1'b1};
   wire [31:0] status_word = {10'h000, out_fault_reg, out_outcome_reg, out_sec_reg,
                              out_valid_reg, sid_reg};
   logic [31:0] rdata_mux;
   always_comb
   begin
      rdata_mux = 32'h0000_0000;
      if (sel_ctrl)
         rdata_mux = {27'h000_0000, ctrl_view};
      else if (sel_alias && apb_secure)
         rdata_mux = {27'h000_0000, ctrl_ns_reg}; // RL10
      else if (sel_dtab && apb_secure)
         rdata_mux = domain_table_register;
      else if (paddr == ssm_pkg::OFF_ID0)
         rdata_mux = id0_word;
      else if (paddr == ssm_pkg::OFF_ID1)
         rdata_mux = id1_word;
      else if (paddr == ssm_pkg::OFF_STATUS)
         rdata_mux = status_word;
      else if (sel_match && entry_visible)
         rdata_mux = match_register[reg_idx];
      else if (sel_s2c && entry_visible)
         rdata_mux = {21'h00_0000, stream_to_context_entry[reg_idx]};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else
      begin
         pready_reg <= apb_setup;
         pslverr_reg <= apb_setup & ~mapped;
         prdata_reg <= (apb_setup & ~pwrite) ? rdata_mux : 32'h0000_0000;
      end
   end

   // banked control copies and the secure-only domain table
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_s_reg <= ssm_pkg::CTRL_RESET;
         ctrl_ns_reg <= ssm_pkg::CTRL_RESET;
         domain_table_register <= ssm_pkg::DTAB_RESET;
      end
      else
      begin
         if (apb_wr && sel_ctrl && apb_secure)
            ctrl_s_reg <= pwdata[4:0]; // RL8
         if (apb_wr && ((sel_ctrl && !apb_secure) || (sel_alias && apb_secure)))
            ctrl_ns_reg <= pwdata[4:0]; // RL8 RL10
         if (apb_wr && sel_dtab && apb_secure)
            domain_table_register <= pwdata; // RL6
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < ssm_pkg::NUM_ENTRIES; i++)
         begin
            match_register[i] <= ssm_pkg::MR_RESET;
            stream_to_context_entry[i] <= ssm_pkg::S2C_RESET;
         end
      end
      else
      begin
         if (apb_wr && sel_match && entry_visible)
            match_register[reg_idx] <= pwdata; // RL9
         if (apb_wr && sel_s2c && entry_visible)
            stream_to_context_entry[reg_idx] <= pwdata[10:0]; // RL9
      end
   end

   // domain decision comes first and picks the control copy used below
   wire dt_bit = domain_table_register[domain_table_index];
   wire use_sideband = ctrl_s_reg[ssm_pkg::CTRL_SIDEBAND];
   wire sec_domain = use_sideband ? txn_sideband_secure : ~dt_bit; // RL1 RL5 RL7 RL3
   wire [4:0] ctrl_use = sec_domain ? ctrl_s_reg : ctrl_ns_reg; // RL1
   wire ext_en = ctrl_use[ssm_pkg::CTRL_EXT_EN];
   wire [15:0] sid_full = {txn_bus_ns, txn_read, txn_id}; // RL13
   wire [15:0] sid = ext_en ? sid_full : {1'b0, sid_full[14:0]}; // RL16 RL17

   logic [7:0] hits;
   always_comb
   begin
      for (int i = 0; i < ssm_pkg::NUM_ENTRIES; i++)
         hits[i] = entry_hit(sid, match_register[i],
                             stream_to_context_entry[i][ssm_pkg::S2C_EXT_VALID],
                             ext_en); // RL18 RL16 RL19 RL20
   end
   wire any_hit = |hits;
   wire multi_hit = (hits & (hits - 8'h01)) != 8'h00; // RL18
   logic [2:0] hit_idx;
   always_comb
   begin
      hit_idx = 3'h0;
      for (int i = ssm_pkg::NUM_ENTRIES - 1; i >= 0; i--)
         if (hits[i])
            hit_idx = 3'(i);
   end
   wire index_mode = ctrl_use[ssm_pkg::CTRL_INDEX];
   wire idx_in_range = sid < 16'(ssm_pkg::NUM_ENTRIES);
   wire [2:0] sel_entry = index_mode ? sid[2:0] : hit_idx; // RL21 RL12
   wire entry_ok = index_mode ? idx_in_range : (any_hit & ~multi_hit);
   wire [10:0] s2c = stream_to_context_entry[sel_entry];

   logic [1:0] outcome_next;
   logic [1:0] fault_next;
   always_comb
   begin
      outcome_next = ssm_pkg::SSM_OUT_BYPASS;
      fault_next = ssm_pkg::SSM_FLT_NONE;
      if (!index_mode && multi_hit)
      begin
         if (ctrl_use[ssm_pkg::CTRL_MULTI])
         begin
            outcome_next = ssm_pkg::SSM_OUT_FAULT; // RL23
            fault_next = ssm_pkg::SSM_FLT_CONFLICT;
         end
      end
      else if (!entry_ok)
      begin
         if (ctrl_use[ssm_pkg::CTRL_NOMATCH])
         begin
            outcome_next = ssm_pkg::SSM_OUT_FAULT; // RL22
            fault_next = ssm_pkg::SSM_FLT_UNIDENT;
         end
      end
      else
      begin
         unique case (s2c[1:0]) // RL11
            2'b00: outcome_next = ssm_pkg::SSM_OUT_TRANSLATE;
            2'b01: outcome_next = ssm_pkg::SSM_OUT_BYPASS;
            default:
            begin
               outcome_next = ssm_pkg::SSM_OUT_FAULT;
               fault_next = ssm_pkg::SSM_FLT_ENTRY;
            end
         endcase
      end
   end
   // secure domain may drop to non-secure; non-secure domain never goes secure
   wire ns_next = ~sec_domain | txn_bus_ns |
                  (entry_ok & s2c[ssm_pkg::S2C_FORCE_NS]); // RL2 RL3

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_valid_reg <= 1'b0;
         out_ns_reg <= 1'b1;
         out_sec_reg <= 1'b0;
         out_outcome_reg <= ssm_pkg::SSM_OUT_BYPASS;
         out_fault_reg <= ssm_pkg::SSM_FLT_NONE;
         out_entry_reg <= 3'h0;
         out_context_reg <= 4'h0;
         sid_reg <= 16'h0000;
      end
      else
      begin
         out_valid_reg <= txn_valid;
         if (txn_valid)
         begin
            out_ns_reg <= ns_next;
            out_sec_reg <= sec_domain;
            out_outcome_reg <= outcome_next;
            out_fault_reg <= fault_next;
            out_entry_reg <= sel_entry;
            out_context_reg <= s2c[ssm_pkg::S2C_CB_LSB +: ssm_pkg::CB_W];
            sid_reg <= sid;
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign out_valid = out_valid_reg;
   assign out_ns = out_ns_reg;
   assign out_secure_domain = out_sec_reg;
   assign out_outcome = out_outcome_reg;
   assign out_fault = out_fault_reg;
   assign out_entry = out_entry_reg;
   assign out_context = out_context_reg;
   assign stream_identifier = sid_reg;

   ns_no_secure_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
      out_valid |-> (out_secure_domain || out_ns))
      else $error("non-secure domain left with secure marking");
   domain_first_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
      txn_valid |=> out_valid && out_secure_domain == $past(sec_domain))
      else $error("domain not decided on the issuing cycle");
   domain_table_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
      (txn_valid && !use_sideband) |=> out_secure_domain == !$past(dt_bit))
      else $error("domain table bit not honoured");
   bank_split_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
      (apb_wr && sel_ctrl && apb_secure) |=> $stable(ctrl_ns_reg))
      else $error("secure control write reached the non-secure copy");
   alias_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL10
      (apb_wr && sel_alias && apb_secure) |=> ctrl_ns_reg == $past(pwdata[4:0]))
      else $error("alias write lost");
   conflict_a: assert property (@(posedge pclk) disable iff (!presetn) // RL23
      (txn_valid && !index_mode && multi_hit && ctrl_use[ssm_pkg::CTRL_MULTI])
      |=> out_fault == ssm_pkg::SSM_FLT_CONFLICT)
      else $error("conflict fault missing");
   no_match_a: assert property (@(posedge pclk) disable iff (!presetn) // RL22
      (txn_valid && !index_mode && !any_hit)
      |=> out_outcome == ($past(ctrl_use[ssm_pkg::CTRL_NOMATCH]) ?
          ssm_pkg::SSM_OUT_FAULT : ssm_pkg::SSM_OUT_BYPASS))
      else $error("no-match action wrong");
   direct_index_a: assert property (@(posedge pclk) disable iff (!presetn) // RL21
      (txn_valid && index_mode) |=> out_entry == $past(sid[2:0]))
      else $error("index mode picked wrong entry");
   unique_hit_a: assert property (@(posedge pclk) disable iff (!presetn) // RL18
      (txn_valid && !index_mode && any_hit && !multi_hit)
      |=> out_entry == $past(hit_idx) && out_fault != ssm_pkg::SSM_FLT_CONFLICT)
      else $error("unique hit mapped wrongly");
   apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready ##1 !pready)
      else $error("apb answer not one cycle later");
   // transaction output format and access guards
   valid_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      !txn_valid
      |=> !out_valid)
      else $error("result without a transaction");
   sid_fields_a: assert property (@(posedge pclk) disable iff (!presetn) // RL13
      txn_valid |=> stream_identifier[13:0] == $past(txn_id) &&
      stream_identifier[14] == $past(txn_read))
      else $error("stream identifier fields wrong");
   sid_narrow_a: assert property (@(posedge pclk) disable iff (!presetn) // RL16
      (txn_valid && !ext_en)
      |=> !stream_identifier[15])
      else $error("narrow identifier kept the top bit");
   sid_wide_a: assert property (@(posedge pclk) disable iff (!presetn) // RL16
      (txn_valid && ext_en)
      |=> stream_identifier[15] == $past(txn_bus_ns))
      else $error("extended identifier lost the top bit");
   bus_ns_kept_a: assert property (@(posedge pclk) disable iff (!presetn) // RL3
      (txn_valid && txn_bus_ns)
      |=> out_ns)
      else $error("non-secure bus marking raised to secure");
   sideband_domain_a: assert property (@(posedge pclk) disable iff (!presetn) // RL7
      (txn_valid && use_sideband)
      |=> out_secure_domain == $past(txn_sideband_secure))
      else $error("sideband domain not honoured");
   table_guard_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
      (apb_wr && sel_dtab && !apb_secure)
      |=> $stable(domain_table_register))
      else $error("non-secure write reached the domain table");
   hidden_entry_a: assert property (@(posedge pclk) disable iff (!presetn) // RL9
      (apb_setup && !pwrite && !apb_secure && (sel_match || sel_s2c) && idx_sec_owned)
      |=> prdata == 32'h0000_0000)
      else $error("secure-owned entry visible to non-secure read");
   unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      (apb_setup && !mapped)
      |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped offset not refused");
   index_range_a: assert property (@(posedge pclk) disable iff (!presetn) // RL21
      (txn_valid && index_mode && !idx_in_range)
      |=> out_outcome != ssm_pkg::SSM_OUT_TRANSLATE)
      else $error("out of range index was translated");
endmodule // ssm_top

// ==== hdl/ssm_top_unused_placeholder_none.sv ====
// intentionally holds no logic; design lives in ssm_top
`timescale 1ns/100ps

// ==== sim/ssm_client_model.sv ====
// upstream client model issuing transactions into the mapping front end
`timescale 1ns/100ps
module ssm_client_model (
   input wire logic clk,
   output logic txn_valid,
   output logic [13:0] txn_id,
   output logic txn_read,
   output logic txn_bus_ns,
   output logic txn_sideband_secure,
   output logic [4:0] domain_table_index
);
   initial
   begin
      {txn_valid, txn_id, txn_read, txn_bus_ns, txn_sideband_secure, domain_table_index} = '0;
   end
   // one request per edge; each call sets the domain inputs, so one stream can take either domain
   task send(input logic [13:0] id, input logic [2:0] f, input logic [4:0] idx);
      @(posedge clk);
      txn_valid <= 1'b1;
      {txn_id, txn_read, txn_bus_ns} <= {id, f[2:1]};
      {txn_sideband_secure, domain_table_index} <= {f[0], idx};
   endtask
   // released fields flip so stale values never look like a request
   task rest();
      @(posedge clk);
      txn_valid <= 1'b0;
      txn_id <= ~txn_id;
      {txn_read, txn_bus_ns, txn_sideband_secure} <= ~{txn_read, txn_bus_ns, txn_sideband_secure};
      domain_table_index <= ~domain_table_index;
   endtask
endmodule // ssm_client_model

// ==== sim/tb.sv ====
// self-checking bench for the security and stream mapping front end
`timescale 1ns/100ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, lfsr;
   logic [2:0] pprot;
   logic txn_valid, txn_read, txn_bus_ns, txn_sideband_secure;
   logic [13:0] txn_id, rid;
   logic [4:0] domain_table_index, ridx;
   logic out_valid, out_ns, out_secure_domain;
   logic [1:0] out_outcome, out_fault;
   logic [2:0] out_entry;
   logic [3:0] out_context;
   logic [15:0] stream_identifier;
   int miscompares = 0;
   int check_count = 0;
   logic [33:0] apb_q[$];
   logic [57:0] txn_q[$];
   localparam logic [28:0] ALL = 29'h1FFF_FFFF;
   localparam logic [28:0] NO_EC = 29'h1F80_FFFF;
   ssm_top ssm_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pprot,
      .prdata, .pready, .pslverr, .txn_valid, .txn_id, .txn_read, .txn_bus_ns,
      .txn_sideband_secure, .domain_table_index, .out_valid, .out_ns, .out_secure_domain,
      .out_outcome, .out_fault, .out_entry, .out_context, .stream_identifier);
   ssm_client_model ssm_client_model_inst (.clk(pclk), .txn_valid, .txn_id, .txn_read,
      .txn_bus_ns, .txn_sideband_secure, .domain_table_index);
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task print_verdict();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task bad(input string m);
      $display("unexpected at %0t: %s", $time, m);
      miscompares++;
   endtask
   task chk_apb();
      logic [33:0] e;
      check_count++;
      if (apb_q.size() == 0)
         bad("apb answer without request");
      else
      begin
         e = apb_q.pop_front();
         if (pslverr !== e[32] || (!e[33] && prdata !== e[31:0]))
            bad("apb answer");
      end
   endtask
   task chk_txn();
      logic [57:0] e;
      logic [28:0] got;
      got = {out_ns, out_secure_domain, out_outcome, out_fault, out_entry, out_context,
         stream_identifier};
      check_count++;
      if (txn_q.size() == 0)
         bad("result without a request");
      else
      begin
         e = txn_q.pop_front();
         if (((got ^ e[28:0]) & e[57:29]) !== 29'h0)
            bad("transaction result");
      end
   endtask
   always @(negedge pclk)
   begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
         chk_apb();
      if (out_valid === 1'b1)
         chk_txn();
   end
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ns,
      input logic [31:0] x, input logic err);
      int i;
      apb_q.push_back({w, err, x});
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata, pprot} <= {2'b10, w, a, d, 1'b0, ns, 1'b0};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(negedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 16);
      if (pready !== 1'b1)
      begin
         bad("apb timeout");
         print_verdict();
      end
      else
      begin
         @(posedge pclk);
         {psel, penable} <= 2'b00;
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic ns);
      apb(1'b1, a, d, ns, 32'h0, 1'b0);
   endtask
   task rd(input logic [11:0] a, input logic ns, input logic [31:0] x);
      apb(1'b0, a, 32'h0, ns, x, 1'b0);
   endtask
   // f = {read, bus_ns, sideband}
   task tx(input logic [13:0] id, input logic [2:0] f, input logic [4:0] idx,
      input logic [28:0] e, input logic [28:0] m);
      txn_q.push_back({m, e});
      ssm_client_model_inst.send(id, f, idx);
      ssm_client_model_inst.rest();
   endtask
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pprot} = '0;
      lfsr = 32'hba36_5f6a;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(ssm_pkg::OFF_ID0, 1'b0, 32'h0000_003F);
      rd(ssm_pkg::OFF_ID1, 1'b0, 32'h0000_0001);
      rd(ssm_pkg::OFF_DTAB, 1'b0, 32'hFFFF_FFFF);
      apb(1'b0, 12'h040, 32'h0, 1'b0, 32'h0, 1'b1);
      apb(1'b0, 12'h0A0, 32'h0, 1'b0, 32'h0, 1'b1);
      tx(14'h0003, 3'b000, 5'h00, {2'h2, 4'h4, 7'h00, 16'h0003}, NO_EC);
      wr(ssm_pkg::OFF_DTAB, 32'hFFFF_FFFE, 1'b0);
      wr(ssm_pkg::OFF_DTAB, 32'h0000_0000, 1'b1);
      rd(ssm_pkg::OFF_DTAB, 1'b0, 32'hFFFF_FFFE);
      rd(ssm_pkg::OFF_DTAB, 1'b1, 32'h0);
      wr(ssm_pkg::OFF_CTRL, 32'h0000_0008, 1'b0);
      wr(ssm_pkg::OFF_CTRL, 32'h0000_0006, 1'b1);
      rd(ssm_pkg::OFF_CTRL, 1'b0, 32'h0000_0008);
      rd(ssm_pkg::OFF_CTRL, 1'b1, 32'h0000_0006);
      rd(ssm_pkg::OFF_CTRL_ALIAS, 1'b0, 32'h0000_0006);
      wr(ssm_pkg::OFF_CTRL_ALIAS, 32'h0000_0002, 1'b0);
      rd(ssm_pkg::OFF_CTRL, 1'b1, 32'h0000_0002);
      wr(ssm_pkg::OFF_S2C + 12'h00C, 32'h0000_0050, 1'b0);
      tx(14'h0003, 3'b000, 5'h00, {2'h1, 4'h0, 7'h35, 16'h0003}, ALL);
      tx(14'h0003, 3'b010, 5'h00, {2'h3, 4'h0, 7'h35, 16'h0003}, ALL);
      tx(14'h0008, 3'b000, 5'h00, {2'h1, 4'h4, 7'h00, 16'h0008}, NO_EC);
      wr(ssm_pkg::OFF_MATCH + 12'h004, 32'h8000_0005, 1'b1);
      wr(ssm_pkg::OFF_S2C + 12'h004, 32'h0000_0020, 1'b1);
      tx(14'h0005, 3'b010, 5'h01, {2'h2, 4'h0, 7'h12, 16'h0005}, ALL);
      tx(14'h0009, 3'b010, 5'h01, {2'h2, 4'h9, 7'h00, 16'h0009}, NO_EC);
      wr(ssm_pkg::OFF_MATCH + 12'h008, 32'h8001_0004, 1'b1);
      tx(14'h0004, 3'b010, 5'h01, {2'h2, 4'hB, 7'h00, 16'h0004}, NO_EC);
      tx(14'h0005, 3'b010, 5'h01, {2'h2, 4'h4, 7'h00, 16'h0005}, NO_EC);
      wr(ssm_pkg::OFF_CTRL, 32'h0000_0006, 1'b1);
      tx(14'h0005, 3'b010, 5'h01, {2'h2, 4'hA, 7'h00, 16'h0005}, NO_EC);
      wr(ssm_pkg::OFF_S2C + 12'h010, 32'h0000_0100, 1'b0);
      rd(ssm_pkg::OFF_S2C + 12'h010, 1'b1, 32'h0);
      wr(ssm_pkg::OFF_S2C + 12'h010, 32'h0, 1'b1);
      rd(ssm_pkg::OFF_S2C + 12'h010, 1'b0, 32'h0000_0100);
      wr(ssm_pkg::OFF_CTRL, 32'h0000_0001, 1'b0);
      wr(ssm_pkg::OFF_MATCH + 12'h00C, 32'h0000_8007, 1'b0);
      wr(ssm_pkg::OFF_S2C + 12'h00C, 32'h0000_0240, 1'b0);
      tx(14'h0007, 3'b010, 5'h00, {2'h3, 4'h0, 7'h34, 16'h8007}, ALL);
      tx(14'h0007, 3'b110, 5'h00, {2'h3, 4'h4, 7'h00, 16'hC007}, NO_EC);
      for (int i = 0; i < 24; i++)
      begin
         lfsr = lfsr_next(lfsr);
         rid = lfsr[13:0] | 14'h0100;
         ridx = (lfsr[20:16] == 5'h00) ? 5'h01 : lfsr[20:16];
         txn_q.push_back({NO_EC, 2'h2, 4'h9, 7'h00, 1'b0, lfsr[14], rid});
         ssm_client_model_inst.send(rid, lfsr[14:12], ridx);
      end
      ssm_client_model_inst.rest();
      wr(ssm_pkg::OFF_CTRL, 32'h0000_0010, 1'b0);
      tx(14'h0009, 3'b000, 5'h00, {2'h2, 4'h9, 7'h00, 16'h0009}, NO_EC);
      tx(14'h0009, 3'b001, 5'h01, {2'h1, 4'h4, 7'h00, 16'h0009}, NO_EC);
      wr(ssm_pkg::OFF_S2C + 12'h008, 32'h0000_0421, 1'b0);
      tx(14'h0004, 3'b001, 5'h01, {2'h3, 4'h4, 7'h22, 16'h0004}, ALL);
      rd(ssm_pkg::OFF_STATUS, 1'b0, 32'h0006_0004);
      repeat (4) @(posedge pclk);
      if (txn_q.size() != 0 || apb_q.size() != 0)
         bad("results missing");
      print_verdict();
   end
endmodule // tb
